/* File: design/ddi_params.svh */
`ifndef DDI_PARAMS_SVH
`define DDI_PARAMS_SVH

// Register byte offsets on the Avalon-MM slave.
`define DDI_OFS_STATUS    6'h00
`define DDI_OFS_CONFIG    6'h04
`define DDI_OFS_LAST_ACT  6'h08
`define DDI_OFS_BURST     6'h0C
`define DDI_OFS_MR_BASE   6'h10
`define DDI_OFS_MR_LAST   6'h28

// Status and config register field positions.
`define DDI_STAT_ST_LSB   0
`define DDI_STAT_ODT_BIT  6
`define DDI_STAT_RDY_BIT  7
`define DDI_STAT_ERR_LSB  8
`define DDI_STAT_MRD_LSB  13
`define DDI_CFG_X8_BIT    0

// Error bit positions inside the sticky error field.
`define DDI_ERR_SEQ       0
`define DDI_ERR_CKE       1
`define DDI_ERR_TEN       2
`define DDI_ERR_ODT       3
`define DDI_ERR_BANK      4

// Mode register contents taken at reset, and the mask for all seven registers written.
`define DDI_MR_DEFAULT    14'h0000
`define DDI_MR_ALL_DONE   7'h7F

// Burst shape: one internal word over four memory clock (CK) rising edges.
`define DDI_BURST_CK      3'h4
`define DDI_BEATS_BL8     4'h8
`define DDI_BEATS_BC4     4'h4

// Timing: internal init wait after reset release, and calibration wait in clocks.
`define DDI_CLK_MHZ       125
`define DDI_T_INIT_US     500
`define DDI_INIT_WAIT_CYC (`DDI_T_INIT_US * `DDI_CLK_MHZ)
`define DDI_ZQ_CAL_CK     1024

`endif

/* File: design/ddi_pkg.sv */
package ddi_pkg;

  typedef enum logic [5:0] {
    ST_RESET   = 6'b00_0001,
    ST_INTINIT = 6'b00_0010,
    ST_WAITCKE = 6'b00_0100,
    ST_MODE    = 6'b00_1000,
    ST_CAL     = 6'b01_0000,
    ST_READY   = 6'b10_0000
  } ddi_state_t;

  typedef enum logic [3:0] {
    CMD_DES = 4'h0,
    CMD_NOP = 4'h1,
    CMD_ACT = 4'h2,
    CMD_MRS = 4'h3,
    CMD_REF = 4'h4,
    CMD_PRE = 4'h5,
    CMD_WR  = 4'h6,
    CMD_RD  = 4'h7,
    CMD_ZQC = 4'h8
  } ddi_cmd_t;

  typedef struct packed {
    logic        ck_prev;
    logic        valid;
    ddi_cmd_t    cmd;
    logic [1:0]  bg;
    logic [1:0]  ba;
    logic [16:0] addr;
    logic        cke;
    logic        odt;
    logic        ten;
  } ddi_dec_st_t;

  typedef struct packed {
    ddi_state_t       st;
    logic [16:0]      cnt;
    logic [6:0]       mr_done;
    logic [6:0][13:0] mr;
    logic [15:0]      bank_open;
    logic [2:0]       burst_cnt;
    logic [3:0]       burst_beats;
    logic             odt_en;
    logic             odt_ref;
    logic [4:0]       err;
    logic             x8;
    logic             ack;
    logic [31:0]      rdata;
    logic [20:0]      last_act;
  } ddi_top_st_t;

endpackage

/* File: design/ddi_cmd_if.sv */
`timescale 1ns/1ns
interface ddi_cmd_if;
  logic              valid;
  ddi_pkg::ddi_cmd_t cmd;
  logic [1:0]        bg;
  logic [1:0]        ba;
  logic [16:0]       addr;
  logic              cke;
  logic              odt;
  logic              ten;

  modport dec (output valid, cmd, bg, ba, addr, cke, odt, ten);
  modport cons (input valid, cmd, bg, ba, addr, cke, odt, ten);
endinterface // ddi_cmd_if

/* File: design/ddi_sync.sv */
`timescale 1ns/1ns
module ddi_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk_i,
  input  wire logic         arst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stab;
  } ddi_sync_st_t;

  ddi_sync_st_t q;
  ddi_sync_st_t d;

  always_comb begin
    d      = q;
    d.meta = d_i;
    d.stab = q.meta;
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign q_o = q.stab;
endmodule // ddi_sync

/* File: design/ddi_cmd_dec.sv */
`timescale 1ns/1ns
// Finds rising edges of the sampled memory clock and registers the command present there.
module ddi_cmd_dec (
  input  wire logic        sys_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        ck_i,
  input  wire logic        cs_n_i,
  input  wire logic        act_n_i,
  input  wire logic        ras_n_i,
  input  wire logic        cas_n_i,
  input  wire logic        we_n_i,
  input  wire logic [1:0]  bg_i,
  input  wire logic [1:0]  ba_i,
  input  wire logic [13:0] addr_i,
  input  wire logic        cke_i,
  input  wire logic        odt_i,
  input  wire logic        ten_i,
  ddi_cmd_if.dec           cmd_o
);
  ddi_pkg::ddi_dec_st_t q;
  ddi_pkg::ddi_dec_st_t d;
  ddi_pkg::ddi_cmd_t    cmd_now;

  always_comb begin
    if (cs_n_i) begin
      cmd_now = ddi_pkg::CMD_DES;
    end else if (!act_n_i) begin
      cmd_now = ddi_pkg::CMD_ACT;
    end else begin
      case ({ras_n_i, cas_n_i, we_n_i})
        3'b000:  cmd_now = ddi_pkg::CMD_MRS;
        3'b001:  cmd_now = ddi_pkg::CMD_REF;
        3'b010:  cmd_now = ddi_pkg::CMD_PRE;
        3'b100:  cmd_now = ddi_pkg::CMD_WR;
        3'b101:  cmd_now = ddi_pkg::CMD_RD;
        3'b110:  cmd_now = ddi_pkg::CMD_ZQC;
        default: cmd_now = ddi_pkg::CMD_NOP;
      endcase
    end
  end

  always_comb begin
    d         = q;
    d.ck_prev = ck_i;
    d.valid   = ck_i & ~q.ck_prev;
    if (ck_i && !q.ck_prev) begin
      d.cmd  = cmd_now;
      d.bg   = bg_i;
      d.ba   = ba_i;
      // With ACT low the command pins carry row bits 16..14.
      d.addr = {ras_n_i, cas_n_i, we_n_i, addr_i};
      d.cke  = cke_i;
      d.odt  = odt_i;
      d.ten  = ten_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign cmd_o.valid = q.valid;
  assign cmd_o.cmd   = q.cmd;
  assign cmd_o.bg    = q.bg;
  assign cmd_o.ba    = q.ba;
  assign cmd_o.addr  = q.addr;
  assign cmd_o.cke   = q.cke;
  assign cmd_o.odt   = q.odt;
  assign cmd_o.ten   = q.ten;
endmodule // ddi_cmd_dec

/* File: design/ddi_init_seq.sv */
// The Avalon-MM interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`include "ddi_params.svh"
module ddi_init_seq #(
  parameter int INIT_WAIT_CYC = `DDI_INIT_WAIT_CYC,
  parameter int ZQ_CAL_CK     = `DDI_ZQ_CAL_CK
) (
  input  wire logic        sys_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        ck_i,
  input  wire logic        mem_reset_n_i,
  input  wire logic        cke_i,
  input  wire logic        cs_n_i,
  input  wire logic        act_n_i,
  input  wire logic        ras_n_i,
  input  wire logic        cas_n_i,
  input  wire logic        we_n_i,
  input  wire logic [1:0]  bg_i,
  input  wire logic [1:0]  ba_i,
  input  wire logic [13:0] addr_i,
  input  wire logic        odt_i,
  input  wire logic        ten_i,
  output logic             odt_term_en_o,
  output logic             ready_o,
  input  wire logic [5:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o
);
  localparam int PW = 28;

  logic [PW-1:0]        pins_s;
  logic                 rst_pin_n;
  ddi_cmd_if            cmd_if ();
  ddi_pkg::ddi_top_st_t q;
  ddi_pkg::ddi_top_st_t d;
  logic                 req;
  logic                 wr_take;
  logic [31:0]          rd_word;
  logic [3:0]           bidx;
  logic [3:0]           bl_beats;
  logic [4:0]           err_set;
  logic [2:0]           mr_sel;
  logic                 in_init;
  logic                 rw_start;

  ddi_sync #(
    .W (PW)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .d_i       ({ck_i, mem_reset_n_i, cke_i, cs_n_i, act_n_i, ras_n_i, cas_n_i, we_n_i,
                 bg_i, ba_i, addr_i, odt_i, ten_i}),
    .q_o       (pins_s)
  );

  assign rst_pin_n = pins_s[26];

  ddi_cmd_dec u_dec (
    .sys_clk_i (sys_clk_i),
    .arst_n_i  (arst_n_i),
    .ck_i      (pins_s[27]),
    .cs_n_i    (pins_s[24]),
    .act_n_i   (pins_s[23]),
    .ras_n_i   (pins_s[22]),
    .cas_n_i   (pins_s[21]),
    .we_n_i    (pins_s[20]),
    .bg_i      (pins_s[19:18]),
    .ba_i      (pins_s[17:16]),
    .addr_i    (pins_s[15:2]),
    .cke_i     (pins_s[25]),
    .odt_i     (pins_s[1]),
    .ten_i     (pins_s[0]),
    .cmd_o     (cmd_if.dec)
  );

  assign req     = avs_read_i | avs_write_i;
  assign wr_take = avs_write_i & q.ack;
  assign in_init = (q.st == ddi_pkg::ST_MODE) || (q.st == ddi_pkg::ST_CAL);
  assign mr_sel  = {cmd_if.bg[0], cmd_if.ba};
  // Bank index: the upper group bit exists only on the x8 organization.
  assign bidx    = {q.x8 & cmd_if.bg[1], cmd_if.bg[0], cmd_if.ba};
  assign rw_start = cmd_if.valid && (q.st == ddi_pkg::ST_READY)
                    && ((cmd_if.cmd == ddi_pkg::CMD_RD) || (cmd_if.cmd == ddi_pkg::CMD_WR));

  always_comb begin
    case (q.mr[0][1:0])
      2'b01:   bl_beats = cmd_if.addr[12] ? `DDI_BEATS_BL8 : `DDI_BEATS_BC4;
      2'b10:   bl_beats = `DDI_BEATS_BC4;
      default: bl_beats = `DDI_BEATS_BL8;
    endcase
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    case (avs_address_i)
      `DDI_OFS_STATUS: begin
        rd_word[`DDI_STAT_ST_LSB +: 6] = q.st;
        rd_word[`DDI_STAT_ODT_BIT]     = q.odt_en;
        rd_word[`DDI_STAT_RDY_BIT]     = (q.st == ddi_pkg::ST_READY);
        rd_word[`DDI_STAT_ERR_LSB +: 5] = q.err;
        rd_word[`DDI_STAT_MRD_LSB +: 7] = q.mr_done;
      end
      `DDI_OFS_CONFIG:   rd_word[`DDI_CFG_X8_BIT] = q.x8;
      `DDI_OFS_LAST_ACT: rd_word[20:0] = q.last_act;
      `DDI_OFS_BURST:    rd_word[22:0] = {q.bank_open, q.burst_cnt, q.burst_beats};
      default: begin
        if (avs_address_i >= `DDI_OFS_MR_BASE && avs_address_i <= `DDI_OFS_MR_LAST) begin
          rd_word[13:0] = q.mr[3'(avs_address_i[5:2] - 4'h4)];
        end
      end
    endcase
  end

  always_comb begin
    d       = q;
    err_set = 5'h00;
    d.ack   = req & ~q.ack;
    if (req && !q.ack) begin
      d.rdata = rd_word;
    end
    if (wr_take && avs_address_i == `DDI_OFS_CONFIG && avs_byteenable_i[0]) begin
      d.x8 = avs_writedata_i[`DDI_CFG_X8_BIT];
    end
    if (wr_take && avs_address_i == `DDI_OFS_STATUS && avs_byteenable_i[1]) begin
      d.err = q.err & ~avs_writedata_i[`DDI_STAT_ERR_LSB +: 5];
    end
    if (cmd_if.valid && q.burst_cnt != 3'h0) begin
      d.burst_cnt = q.burst_cnt - 3'h1;
    end
    if (!rst_pin_n) begin
      d.st        = ddi_pkg::ST_RESET;
      d.cnt       = 17'h0_0000;
      d.mr        = {7{`DDI_MR_DEFAULT}};
      d.mr_done   = 7'h00;
      d.bank_open = 16'h0000;
      d.burst_cnt = 3'h0;
      d.odt_en    = 1'b0;
    end else begin
      case (q.st)
        ddi_pkg::ST_RESET: begin
          d.st  = ddi_pkg::ST_INTINIT;
          d.cnt = 17'h0_0000;
        end
        ddi_pkg::ST_INTINIT: begin
          // Internal setup runs on the system clock, not on the memory clock.
          d.cnt = q.cnt + 17'h0_0001;
          if (q.cnt == 17'(INIT_WAIT_CYC - 1)) begin
            d.st = ddi_pkg::ST_WAITCKE;
          end
          if (cmd_if.valid && cmd_if.cke) begin
            err_set[`DDI_ERR_SEQ] = 1'b1;
          end
        end
        ddi_pkg::ST_WAITCKE: begin
          if (cmd_if.valid && cmd_if.cke) begin
            d.st      = ddi_pkg::ST_MODE;
            d.odt_ref = cmd_if.odt;
            d.odt_en  = cmd_if.odt;
          end
        end
        ddi_pkg::ST_MODE: begin
          if (cmd_if.valid && cmd_if.cmd == ddi_pkg::CMD_MRS && mr_sel != 3'h7) begin
            d.mr[mr_sel]      = cmd_if.addr[13:0];
            d.mr_done[mr_sel] = 1'b1;
          end
          if (cmd_if.valid && cmd_if.cmd == ddi_pkg::CMD_ZQC && cmd_if.addr[10]) begin
            if (q.mr_done == `DDI_MR_ALL_DONE) begin
              d.st  = ddi_pkg::ST_CAL;
              d.cnt = 17'h0_0000;
            end else begin
              err_set[`DDI_ERR_SEQ] = 1'b1;
            end
          end
        end
        ddi_pkg::ST_CAL: begin
          if (cmd_if.valid) begin
            d.cnt = q.cnt + 17'h0_0001;
            if (q.cnt == 17'(ZQ_CAL_CK - 1)) begin
              d.st = ddi_pkg::ST_READY;
            end
          end
        end
        ddi_pkg::ST_READY: begin
          if (cmd_if.valid) begin
            d.odt_en = cmd_if.odt;
            case (cmd_if.cmd)
              ddi_pkg::CMD_ACT: begin
                d.bank_open[bidx] = 1'b1;
                d.last_act        = {bidx, cmd_if.addr};
              end
              ddi_pkg::CMD_PRE: begin
                if (cmd_if.addr[10]) begin
                  d.bank_open = 16'h0000;
                end else begin
                  d.bank_open[bidx] = 1'b0;
                end
              end
              ddi_pkg::CMD_RD, ddi_pkg::CMD_WR: begin
                d.burst_cnt   = `DDI_BURST_CK;
                d.burst_beats = bl_beats;
                if (!q.bank_open[bidx]) begin
                  err_set[`DDI_ERR_BANK] = 1'b1;
                end
              end
              default: begin
              end
            endcase
          end
        end
        default: begin
          d.st = ddi_pkg::ST_RESET;
        end
      endcase
      if (in_init && cmd_if.valid) begin
        err_set[`DDI_ERR_CKE] = ~cmd_if.cke;
        err_set[`DDI_ERR_TEN] = cmd_if.ten;
        err_set[`DDI_ERR_ODT] = cmd_if.odt ^ q.odt_ref;
      end
    end
    // A new error in the clearing cycle stays set.
    d.err = d.err | err_set;
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q    <= '0;
      q.st <= ddi_pkg::ST_RESET;
    end else begin
      q <= d;
    end
  end

  assign odt_term_en_o     = q.odt_en;
  assign ready_o           = (q.st == ddi_pkg::ST_READY);
  assign avs_readdata_o    = q.rdata;
  assign avs_waitrequest_o = req & ~q.ack;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence s_reset_held;
    (q.st == ddi_pkg::ST_RESET) [*2];
  endsequence

  sequence s_mrs_taken;
    cmd_if.valid && q.st == ddi_pkg::ST_MODE && cmd_if.cmd == ddi_pkg::CMD_MRS && mr_sel != 3'h7;
  endsequence

  sequence s_act_taken;
    cmd_if.valid && q.st == ddi_pkg::ST_READY && cmd_if.cmd == ddi_pkg::CMD_ACT;
  endsequence

  a_mr_default_load: assert property (
    s_reset_held |-> (q.mr[3][4:3] == 2'h0 && q.mr[4][1] == 1'b0 && q.mr[4][8:6] == 3'h0
                      && q.mr[5][2:0] == 3'h0))
    else $error("mode defaults not loaded during reset");

  a_init_wait_len: assert property (
    (q.st == ddi_pkg::ST_INTINIT && d.st == ddi_pkg::ST_WAITCKE && rst_pin_n)
      |-> q.cnt == 17'(INIT_WAIT_CYC - 1))
    else $error("internal init wait ended at wrong count");

  a_odt_hiz_pre_cke: assert property (
    (q.st == ddi_pkg::ST_RESET || q.st == ddi_pkg::ST_INTINIT || q.st == ddi_pkg::ST_WAITCKE)
      |-> !odt_term_en_o)
    else $error("termination on before cke registered");

  a_zq_ready_wait: assert property (
    $rose(ready_o) |-> $past(q.st) == ddi_pkg::ST_CAL && $past(q.cnt) == 17'(ZQ_CAL_CK - 1))
    else $error("ready before calibration wait elapsed");

  a_mrs_shadow_upd: assert property (
    (s_mrs_taken ##0 rst_pin_n) |=> q.mr[$past(mr_sel)] == $past(cmd_if.addr[13:0]))
    else $error("mode register shadow not updated");

  a_burst_length: assert property (
    (rw_start && rst_pin_n && q.mr[0][1:0] == 2'b00) |=> q.burst_beats == `DDI_BEATS_BL8)
    else $error("fixed burst not eight beats");

  a_burst_four_ck: assert property (
    (rw_start && rst_pin_n) |=> q.burst_cnt == `DDI_BURST_CK)
    else $error("burst not spanning four clocks");

  a_act_opens_bank: assert property (
    (s_act_taken ##0 rst_pin_n) |=> q.bank_open[$past(bidx)])
    else $error("activate did not open bank");

  a_x16_groups: assert property (
    !q.x8 |-> ##1 (!q.x8 || q.bank_open[15:8] == $past(q.bank_open[15:8])) || q.bank_open[15:8] == 8'h00
      || $past(q.x8))
    else $error("x16 part opened bank in missing group");

  a_err_sticky_cke: assert property (
    (in_init && cmd_if.valid && !cmd_if.cke && rst_pin_n) |=> q.err[`DDI_ERR_CKE])
    else $error("cke drop during init not flagged");

  a_bus_one_wait: assert property (
    ($rose(req) && !q.ack) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("bus answer not after one wait cycle");
endmodule // ddi_init_seq

/* File: sim/ddi_ctrl_model.sv */
`timescale 1ns/1ns
// Controller side of the memory pins: every pin change except RESET lands on a CK fall, so it is stable at the CK rise.
module ddi_ctrl_model #(
  parameter int GAP_CK  = 8,
  parameter int INIT_NS = 400
) (
  output logic        ck_o,
  output logic        mem_reset_n_o,
  output logic        cke_o,
  output logic        cs_n_o,
  output logic [3:0]  cmd_n_o,
  output logic [1:0]  bg_o,
  output logic [1:0]  ba_o,
  output logic [13:0] addr_o,
  output logic        odt_o,
  output logic        ten_o
);
  logic run;

  initial begin
    {run, ck_o, mem_reset_n_o, cke_o} = 4'h0;
    {cs_n_o, cmd_n_o, bg_o, ba_o, addr_o} = 23'h7F_FFFF;
    odt_o = 1'b1;
    ten_o = 1'b0;
    #3;
    forever #80 if (run) ck_o = ~ck_o;
  end

  // Deselected cycles carry inverted junk so the device cannot lean on stale pins.
  task automatic cmd(input logic [3:0] pins, input logic [1:0] bg, input logic [1:0] ba,
                     input logic [13:0] a, input int gap);
    @(negedge ck_o);
    cs_n_o  <= 1'b0;
    cmd_n_o <= pins;
    bg_o    <= bg;
    ba_o    <= ba;
    addr_o  <= a;
    @(negedge ck_o);
    cs_n_o <= 1'b1;
    {cmd_n_o, bg_o, ba_o, addr_o} <= ~{pins, bg, ba, a};
    repeat (gap) @(negedge ck_o);
  endtask

  task automatic release_reset();
    cke_o <= 1'b0;
    #20;
    mem_reset_n_o <= 1'b1;
    #(INIT_NS);
  endtask

  task automatic raise_cke();
    run = 1'b1;
    repeat (6) @(negedge ck_o);
    cke_o <= 1'b1;
    repeat (GAP_CK) @(negedge ck_o);
  endtask

  task automatic warm_reset();
    @(negedge ck_o);
    cke_o <= 1'b0;
    #20;
    mem_reset_n_o <= 1'b0;
    run = 1'b0;
    #400;
    release_reset();
  endtask

  // Moves CKE on a CK fall; dropping it during initialization provokes the device's error flag on purpose.
  task automatic set_cke(input logic v, input int n);
    @(negedge ck_o);
    cke_o <= v;
    repeat (n) @(negedge ck_o);
  endtask
endmodule // ddi_ctrl_model

/* File: sim/tb.sv */
`timescale 1ns/1ns
module tb;
  logic        sys_clk, arst_n, ck, mem_reset_n, cke, cs_n, odt, ten, ready, term;
  logic        avs_read, avs_write, avs_wait;
  logic [3:0]  cmd_n, avs_be;
  logic [1:0]  bg, ba;
  logic [13:0] addr;
  logic [5:0]  avs_addr;
  logic [31:0] avs_wdata, avs_rdata;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  logic [13:0] mr[7];
  logic [16:0] row;
  logic [2:0]  order[7];
  int          err_count, num_checks, seed;

  always #4 sys_clk = ~sys_clk;

  ddi_init_seq #(.INIT_WAIT_CYC(20), .ZQ_CAL_CK(8)) dut (
    .sys_clk_i(sys_clk), .arst_n_i(arst_n), .ck_i(ck), .mem_reset_n_i(mem_reset_n), .cke_i(cke),
    .cs_n_i(cs_n), .act_n_i(cmd_n[3]), .ras_n_i(cmd_n[2]), .cas_n_i(cmd_n[1]), .we_n_i(cmd_n[0]),
    .bg_i(bg), .ba_i(ba), .addr_i(addr), .odt_i(odt), .ten_i(ten), .odt_term_en_o(term), .ready_o(ready),
    .avs_address_i(avs_addr), .avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_wdata),
    .avs_byteenable_i(avs_be), .avs_readdata_o(avs_rdata), .avs_waitrequest_o(avs_wait));

  ddi_ctrl_model ctrl (
    .ck_o(ck), .mem_reset_n_o(mem_reset_n), .cke_o(cke), .cs_n_o(cs_n), .cmd_n_o(cmd_n), .bg_o(bg),
    .ba_o(ba), .addr_o(addr), .odt_o(odt), .ten_o(ten));

  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be,
                     input logic [33:0] x);
    int n;
    @(posedge sys_clk);
    avs_addr  <= a;
    avs_write <= wr;
    avs_read  <= ~wr;
    avs_wdata <= d;
    avs_be    <= be;
    if (!wr) exp_q.push_back(x);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_wait !== 1'b0 && n < 100);
    if (n >= 100) begin
      err_count++;
      complete_run();
    end
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [33:0] x);
    bus(1'b0, a, 32'h0000_0000, 4'hF, x);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
    bus(1'b1, a, d, be, 34'h0_0000_0000);
  endtask

  // Each completed read is compared together with the ready and termination levels.
  always @(posedge sys_clk) begin
    if (avs_read && avs_wait === 1'b0) begin
      e = exp_q.pop_front();
      num_checks++;
      if ({ready, term, avs_rdata} !== e) begin
        err_count++;
        $display("mismatch t=%0t exp=%h got=%h", $time, e, {ready, term, avs_rdata});
      end
    end
  end

  initial begin
    #600000;
    err_count++;
    complete_run();
  end

  initial begin
    seed = 32'h7fb5;
    order = '{3'h3, 3'h6, 3'h5, 3'h4, 3'h2, 3'h1, 3'h0};
    {sys_clk, arst_n, avs_read, avs_write} = 4'h0;
    {avs_addr, avs_wdata, avs_be} = 42'h0;
    err_count = 0;
    num_checks = 0;
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    rd(6'h00, 34'h0_0000_0001);
    rd(6'h1C, 34'h0_0000_0000);
    rd(6'h3C, 34'h0_0000_0000);
    ctrl.release_reset();
    rd(6'h00, 34'h0_0000_0004);
    ctrl.raise_cke();
    rd(6'h00, 34'h1_0000_0048);
    for (int i = 0; i < 7; i++) begin
      mr[order[i]] = 14'($random(seed));
      if (i == 6) begin
        mr[0][1:0] = 2'b01;
        ctrl.cmd(4'hE, 2'b00, 2'b00, 14'h0400, 2);
        rd(6'h00, 34'h1_000F_C148);
        wr(6'h00, 32'h0000_0100, 4'b0010);
      end
      ctrl.cmd(4'h8, {1'b0, order[i][2]}, order[i][1:0], mr[order[i]], 8);
    end
    rd(6'h00, 34'h1_000F_E048);
    for (int n = 0; n < 7; n++) rd(6'h10 + 6'(4 * n), {2'b01, 18'h0_0000, mr[n]});
    wr(6'h14, $random(seed), 4'hF);
    rd(6'h14, {2'b01, 18'h0_0000, mr[1]});
    ctrl.cmd(4'hE, 2'b00, 2'b00, 14'h0400, 10);
    rd(6'h00, 34'h3_000F_E0E0);
    wr(6'h04, 32'h0000_0001, 4'b0001);
    rd(6'h04, 34'h3_0000_0001);
    row = 17'($random(seed));
    ctrl.cmd({1'b0, row[16:14]}, 2'b11, 2'b10, row[13:0], 2);
    rd(6'h08, {2'b11, 11'h000, 4'hE, row});
    ctrl.cmd(4'hD, 2'b11, 2'b10, 14'h1000, 6);
    rd(6'h0C, 34'h3_0020_0008);
    ctrl.cmd(4'hC, 2'b11, 2'b10, 14'h0000, 6);
    rd(6'h0C, 34'h3_0020_0004);
    ctrl.cmd(4'hD, 2'b00, 2'b00, 14'h0000, 2);
    rd(6'h00, 34'h3_000F_F0E0);
    ctrl.warm_reset();
    rd(6'h00, 34'h0_0000_1004);
    rd(6'h1C, 34'h0_0000_0000);
    ctrl.raise_cke();
    rd(6'h00, 34'h1_0000_1048);
    // Second initialization uses fixed eight-beat bursts, so the low mode bits are cleared.
    for (int i = 0; i < 7; i++) begin
      mr[order[i]] = 14'($random(seed)) & 14'h3FFC;
      ctrl.cmd(4'h8, {1'b0, order[i][2]}, order[i][1:0], mr[order[i]], 8);
    end
    ctrl.cmd(4'hE, 2'b00, 2'b00, 14'h0400, 0);
    ctrl.set_cke(1'b0, 2);
    rd(6'h00, 34'h1_000F_F250);
    ctrl.set_cke(1'b1, 8);
    rd(6'h00, 34'h3_000F_F2E0);
    ctrl.cmd(4'h0, 2'b00, 2'b01, 14'h0000, 2);
    ctrl.cmd(4'hD, 2'b00, 2'b01, 14'h0000, 6);
    rd(6'h0C, 34'h3_0000_0108);
    rd(6'h00, 34'h3_000F_F2E0);
    ctrl.cmd(4'hA, 2'b00, 2'b01, 14'h0000, 2);
    rd(6'h0C, 34'h3_0000_0008);
    @(posedge sys_clk);
    complete_run();
  end
endmodule // tb
